/* File: design/fcx_pkg.sv */
// Constants and types for the flag-control and compare execution unit
// Overview of operation
// - Clear-carry zeroes carry; one byte, 2 clocks
// - Clear-direction resets direction; one byte, 2 clocks
// - Clear-interrupt resets enable; one byte, 2 clocks
// - Complement-carry inverts carry only; 2 clocks
// - Compare clocks 3, 4, 9+addr, 10+addr
// - Compare lengths follow operand form and displacement
// - Single string compare: 22 clocks, two transfers
// - Repeated string compare: 9 plus 22 per pass
// - Wide bus: odd word transfer adds four
// - Narrow bus: every word transfer adds four
package fcx_pkg;
    typedef enum logic [2:0] {
        FCX_CLEAR_CARRY_OP = 3'h0,
        FCX_CLEAR_DIRECTION_OP = 3'h1,
        FCX_CLEAR_INTERRUPT_ENABLE_OP = 3'h2,
        FCX_COMPLEMENT_CARRY_OP = 3'h3,
        FCX_COMPARE_OP = 3'h4,
        FCX_STRING_COMPARE_OP = 3'h5
    } fcx_op_e;

    typedef enum logic [2:0] {
        FCX_FORM_REG_REG = 3'h0,
        FCX_FORM_REG_MEM = 3'h1,
        FCX_FORM_MEM_REG = 3'h2,
        FCX_FORM_REG_IMM = 3'h3,
        FCX_FORM_MEM_IMM = 3'h4,
        FCX_FORM_ACC_IMM = 3'h5
    } fcx_form_e;

    typedef enum logic [1:0] {
        FCX_ST_IDLE = 2'h0,
        FCX_ST_RUN = 2'h1,
        FCX_ST_SETUP = 2'h3,
        FCX_ST_STR = 2'h2
    } fcx_state_e;

    // Flag word bit positions
    localparam int FCX_FLAG_C = 0;
    localparam int FCX_FLAG_P = 2;
    localparam int FCX_FLAG_A = 4;
    localparam int FCX_FLAG_Z = 6;
    localparam int FCX_FLAG_S = 7;
    localparam int FCX_FLAG_I = 9;
    localparam int FCX_FLAG_D = 10;
    localparam int FCX_FLAG_O = 11;
    localparam logic [15:0] FCX_ARITH_MASK = 16'h08d5;
    localparam logic [15:0] FCX_FLAGS_RST = 16'h0000;

    // Clock budgets
    localparam logic [15:0] FCX_CLK_FLAG = 16'h0002;
    localparam logic [15:0] FCX_CLK_CMP_RR = 16'h0003;
    localparam logic [15:0] FCX_CLK_CMP_MEM = 16'h0009;
    localparam logic [15:0] FCX_CLK_CMP_IMM = 16'h0004;
    localparam logic [15:0] FCX_CLK_CMP_MEM_IMM = 16'h000a;
    localparam logic [15:0] FCX_CLK_STR = 16'h0016;
    localparam logic [15:0] FCX_CLK_REP_SETUP = 16'h0009;
    localparam logic [15:0] FCX_CLK_WORD_PEN = 16'h0004;

    // Encoded lengths in bytes
    localparam logic [2:0] FCX_LEN_ONE = 3'h1;
    localparam logic [2:0] FCX_LEN_MODRM = 3'h2;
    localparam logic [2:0] FCX_LEN_ACC_BASE = 3'h1;
endpackage : fcx_pkg

/* File: design/fcx_alu_if.sv */
// Operand and flag carrier between the exec unit and its subtractor
`timescale 1ns/1ps
`default_nettype none
interface fcx_alu_if;
    logic [15:0] dst;
    logic [15:0] src;
    logic word;
    logic [15:0] flags;
    modport alu (input dst, input src, input word, output flags);
    modport user (output dst, output src, output word, input flags);
endinterface : fcx_alu_if
`default_nettype wire

/* File: design/fcx_cmp_alu.sv */
// Compare subtractor producing arithmetic status flags
`timescale 1ns/1ps
`default_nettype none
module fcx_cmp_alu
    import fcx_pkg::*;
(
    fcx_alu_if.alu bus
);
    logic [16:0] diff;
    logic [15:0] res;
    logic msb_r;
    logic msb_d;
    logic msb_s;
    logic borrow;

    // Difference only feeds flags; it never returns to an operand
    always_comb begin
        diff = {1'b0, bus.dst} - {1'b0, bus.src};
        res = diff[15:0];
        if (bus.word) begin
            msb_r = res[15];
            msb_d = bus.dst[15];
            msb_s = bus.src[15];
            borrow = diff[16];
        end else begin
            msb_r = res[7];
            msb_d = bus.dst[7];
            msb_s = bus.src[7];
            borrow = bus.dst[7:0] < bus.src[7:0];
        end
        bus.flags = 16'h0000;
        bus.flags[FCX_FLAG_C] = borrow;
        bus.flags[FCX_FLAG_P] = ~^res[7:0];
        bus.flags[FCX_FLAG_A] = bus.dst[4] ^ bus.src[4] ^ res[4];
        bus.flags[FCX_FLAG_Z] = bus.word ? (res == 16'h0000) : (res[7:0] == 8'h00);
        bus.flags[FCX_FLAG_S] = msb_r;
        bus.flags[FCX_FLAG_O] = (msb_d ^ msb_s) & (msb_d ^ msb_r);
    end
endmodule : fcx_cmp_alu
`default_nettype wire

/* File: design/fcx_exec_unit.sv */
// Flag-control and compare execution unit with cycle budgets
`timescale 1ns/1ps
`default_nettype none
module fcx_exec_unit
    import fcx_pkg::*;
#(
    parameter bit BUS8 = 1'b0
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic op_valid,
    input wire logic [2:0] op_code,
    input wire logic [2:0] cmp_form,
    input wire logic op_word,
    input wire logic [15:0] dst_val,
    input wire logic [15:0] src_val,
    input wire logic mem_odd,
    input wire logic [7:0] effective_address_time,
    input wire logic [1:0] disp_len,
    input wire logic repeat_while_equal_prefix,
    input wire logic [15:0] src_addr,
    input wire logic [15:0] dst_addr,
    input wire logic [15:0] rep_count,
    input wire logic [15:0] mem_rd_data,
    input wire logic mem_rd_valid,
    output logic busy,
    output logic done,
    output logic [15:0] flags,
    output logic [2:0] enc_len,
    output logic [15:0] xfer_cnt,
    output logic mem_rd_req,
    output logic [15:0] mem_rd_addr,
    output logic [15:0] src_ptr,
    output logic [15:0] dst_ptr,
    output logic [15:0] count
);
    fcx_state_e state_ff, nxt_state;
    fcx_op_e op_ff, nxt_op;
    logic [15:0] cnt_ff, nxt_cnt;
    logic [15:0] flags_ff, nxt_flags;
    logic busy_ff, nxt_busy;
    logic done_ff, nxt_done;
    logic word_ff, nxt_word;
    logic [15:0] a_ff, nxt_a;
    logic [15:0] b_ff, nxt_b;
    logic [2:0] len_ff, nxt_len;
    logic [15:0] xfer_ff, nxt_xfer;
    logic rd_req_ff, nxt_rd_req;
    logic [15:0] rd_addr_ff, nxt_rd_addr;
    logic [1:0] phase_ff, nxt_phase;
    logic [15:0] sp_ff, nxt_sp;
    logic [15:0] dp_ff, nxt_dp;
    logic [15:0] count_ff, nxt_count;
    logic rep_ff, nxt_rep;
    logic [15:0] cmp_flags;
    logic [15:0] mem_pen;
    logic [15:0] step;
    logic [15:0] cnt_left;
    logic [2:0] imm_len;

    fcx_alu_if alu_bus ();
    assign alu_bus.dst = a_ff;
    assign alu_bus.src = b_ff;
    assign alu_bus.word = word_ff;

    fcx_cmp_alu u_alu (
        .bus(alu_bus)
    );

    // Word transfer penalty per bus variant
    function automatic logic [15:0] word_pen(input logic w, input logic odd);
        word_pen = (w && (BUS8 || odd)) ? FCX_CLK_WORD_PEN : 16'h0000;
    endfunction

    // One pass: fixed base plus a penalty for each of its two reads
    function automatic logic [15:0] str_budget(input logic w, input logic [15:0] sa, input logic [15:0] da);
        str_budget = FCX_CLK_STR + word_pen(w, sa[0]) + word_pen(w, da[0]) - 16'h0001;
    endfunction

    always_comb begin
        cmp_flags = (flags_ff & ~FCX_ARITH_MASK) | (alu_bus.flags & FCX_ARITH_MASK);
        mem_pen = word_pen(op_word, mem_odd);
        step = word_ff ? 16'h0002 : 16'h0001;
        cnt_left = count_ff - 16'h0001;
        imm_len = op_word ? 3'h2 : 3'h1;
        nxt_state = state_ff;
        nxt_op = op_ff;
        nxt_cnt = cnt_ff;
        nxt_flags = flags_ff;
        nxt_busy = busy_ff;
        nxt_done = 1'b0;
        nxt_word = word_ff;
        nxt_a = a_ff;
        nxt_b = b_ff;
        nxt_len = len_ff;
        nxt_xfer = xfer_ff;
        nxt_rd_req = 1'b0;
        nxt_rd_addr = rd_addr_ff;
        nxt_phase = phase_ff;
        nxt_sp = sp_ff;
        nxt_dp = dp_ff;
        nxt_count = count_ff;
        nxt_rep = rep_ff;
        case (state_ff)
            FCX_ST_IDLE: begin
                if (op_valid) begin
                    nxt_op = fcx_op_e'(op_code);
                    nxt_word = op_word;
                    nxt_a = dst_val;
                    nxt_b = src_val;
                    nxt_busy = 1'b1;
                    nxt_xfer = 16'h0000;
                    nxt_len = FCX_LEN_ONE;
                    nxt_cnt = FCX_CLK_FLAG - 16'h0001;
                    nxt_state = FCX_ST_RUN;
                    case (fcx_op_e'(op_code))
                        FCX_COMPARE_OP: begin
                            case (fcx_form_e'(cmp_form))
                                FCX_FORM_REG_REG: begin
                                    nxt_cnt = FCX_CLK_CMP_RR - 16'h0001;
                                    nxt_len = FCX_LEN_MODRM;
                                end
                                FCX_FORM_REG_MEM, FCX_FORM_MEM_REG: begin
                                    nxt_cnt = FCX_CLK_CMP_MEM + 16'(effective_address_time) + mem_pen - 16'h0001;
                                    nxt_len = FCX_LEN_MODRM + 3'(disp_len);
                                    nxt_xfer = 16'h0001;
                                end
                                FCX_FORM_REG_IMM: begin
                                    nxt_cnt = FCX_CLK_CMP_IMM - 16'h0001;
                                    nxt_len = FCX_LEN_MODRM + imm_len;
                                end
                                FCX_FORM_MEM_IMM: begin
                                    nxt_cnt = FCX_CLK_CMP_MEM_IMM + 16'(effective_address_time) + mem_pen - 16'h0001;
                                    nxt_len = FCX_LEN_MODRM + 3'(disp_len) + imm_len;
                                    nxt_xfer = 16'h0001;
                                end
                                default: begin
                                    nxt_cnt = FCX_CLK_CMP_IMM - 16'h0001;
                                    nxt_len = FCX_LEN_ACC_BASE + imm_len;
                                end
                            endcase
                        end
                        FCX_STRING_COMPARE_OP: begin
                            nxt_sp = src_addr;
                            nxt_dp = dst_addr;
                            nxt_count = rep_count;
                            nxt_rep = repeat_while_equal_prefix;
                            nxt_phase = 2'h0;
                            if (repeat_while_equal_prefix) begin
                                nxt_cnt = FCX_CLK_REP_SETUP - 16'h0001;
                                nxt_state = FCX_ST_SETUP;
                            end else begin
                                nxt_cnt = str_budget(op_word, src_addr, dst_addr);
                                nxt_state = FCX_ST_STR;
                            end
                        end
                        default: ;
                    endcase
                end
            end
            FCX_ST_RUN: begin
                if (cnt_ff == 16'h0000) begin
                    nxt_busy = 1'b0;
                    nxt_done = 1'b1;
                    nxt_state = FCX_ST_IDLE;
                    case (op_ff)
                        FCX_CLEAR_CARRY_OP: nxt_flags[FCX_FLAG_C] = 1'b0;
                        FCX_CLEAR_DIRECTION_OP: nxt_flags[FCX_FLAG_D] = 1'b0;
                        FCX_CLEAR_INTERRUPT_ENABLE_OP: nxt_flags[FCX_FLAG_I] = 1'b0;
                        FCX_COMPLEMENT_CARRY_OP: nxt_flags[FCX_FLAG_C] = ~flags_ff[FCX_FLAG_C];
                        FCX_COMPARE_OP: nxt_flags = cmp_flags;
                        default: ;
                    endcase
                end else begin
                    nxt_cnt = cnt_ff - 16'h0001;
                end
            end
            FCX_ST_SETUP: begin
                if (cnt_ff != 16'h0000) begin
                    nxt_cnt = cnt_ff - 16'h0001;
                end else if (count_ff == 16'h0000) begin
                    // Zero count: setup only, no pass and no flag change
                    nxt_busy = 1'b0;
                    nxt_done = 1'b1;
                    nxt_state = FCX_ST_IDLE;
                end else begin
                    nxt_cnt = str_budget(word_ff, sp_ff, dp_ff);
                    nxt_phase = 2'h0;
                    nxt_state = FCX_ST_STR;
                end
            end
            FCX_ST_STR: begin
                if (cnt_ff != 16'h0000) begin
                    nxt_cnt = cnt_ff - 16'h0001;
                end
                case (phase_ff)
                    2'h0: begin
                        nxt_rd_req = 1'b1;
                        nxt_rd_addr = sp_ff;
                        nxt_phase = 2'h1;
                    end
                    2'h1: begin
                        if (mem_rd_valid) begin
                            nxt_b = mem_rd_data;
                            nxt_rd_req = 1'b1;
                            nxt_rd_addr = dp_ff;
                            nxt_phase = 2'h2;
                        end
                    end
                    2'h2: begin
                        if (mem_rd_valid) begin
                            nxt_a = mem_rd_data;
                            nxt_phase = 2'h3;
                        end
                    end
                    default: begin
                        // Slow memory stretches the pass past its budget
                        if (cnt_ff == 16'h0000) begin
                            nxt_flags = cmp_flags;
                            nxt_xfer = xfer_ff + 16'h0002;
                            nxt_sp = flags_ff[FCX_FLAG_D] ? sp_ff - step : sp_ff + step;
                            nxt_dp = flags_ff[FCX_FLAG_D] ? dp_ff - step : dp_ff + step;
                            nxt_phase = 2'h0;
                            if (rep_ff) begin
                                nxt_count = cnt_left;
                            end
                            if (rep_ff && cnt_left != 16'h0000 && alu_bus.flags[FCX_FLAG_Z]) begin
                                nxt_cnt = str_budget(word_ff, nxt_sp, nxt_dp);
                            end else begin
                                nxt_busy = 1'b0;
                                nxt_done = 1'b1;
                                nxt_state = FCX_ST_IDLE;
                            end
                        end
                    end
                endcase
            end
            default: begin
                nxt_state = FCX_ST_IDLE;
                nxt_busy = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_ff <= FCX_ST_IDLE;
            op_ff <= FCX_CLEAR_CARRY_OP;
            cnt_ff <= 16'h0000;
            flags_ff <= FCX_FLAGS_RST;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
            word_ff <= 1'b0;
            a_ff <= 16'h0000;
            b_ff <= 16'h0000;
            len_ff <= 3'h0;
            xfer_ff <= 16'h0000;
            rd_req_ff <= 1'b0;
            rd_addr_ff <= 16'h0000;
            phase_ff <= 2'h0;
            sp_ff <= 16'h0000;
            dp_ff <= 16'h0000;
            count_ff <= 16'h0000;
            rep_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            op_ff <= nxt_op;
            cnt_ff <= nxt_cnt;
            flags_ff <= nxt_flags;
            busy_ff <= nxt_busy;
            done_ff <= nxt_done;
            word_ff <= nxt_word;
            a_ff <= nxt_a;
            b_ff <= nxt_b;
            len_ff <= nxt_len;
            xfer_ff <= nxt_xfer;
            rd_req_ff <= nxt_rd_req;
            rd_addr_ff <= nxt_rd_addr;
            phase_ff <= nxt_phase;
            sp_ff <= nxt_sp;
            dp_ff <= nxt_dp;
            count_ff <= nxt_count;
            rep_ff <= nxt_rep;
        end
    end

    assign busy = busy_ff;
    assign done = done_ff;
    assign flags = flags_ff;
    assign enc_len = len_ff;
    assign xfer_cnt = xfer_ff;
    assign mem_rd_req = rd_req_ff;
    assign mem_rd_addr = rd_addr_ff;
    assign src_ptr = sp_ff;
    assign dst_ptr = dp_ff;
    assign count = count_ff;
endmodule : fcx_exec_unit
`default_nettype wire

/* File: sim/fcx_exec_unit_sva.sv */
// Port-level assertion checker for the flag-control and compare unit
`timescale 1ns/1ps
`default_nettype none
module fcx_exec_unit_sva
    import fcx_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic op_valid,
    input wire logic [2:0] op_code,
    input wire logic [2:0] cmp_form,
    input wire logic op_word,
    input wire logic repeat_while_equal_prefix,
    input wire logic [15:0] rep_count,
    input wire logic busy,
    input wire logic done,
    input wire logic [15:0] flags,
    input wire logic [2:0] enc_len,
    input wire logic [15:0] xfer_cnt
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    logic go;
    logic rep;
    assign go = op_valid && !busy;
    assign rep = repeat_while_equal_prefix;
    property p_flag_time;
        go && op_code < 3'h4 |=> busy ##1 busy ##1 (done && !busy);
    endproperty
    a_flag_time: assert property (p_flag_time) else $error("flag op timing");
    property p_clr_c;
        go && op_code == 3'h0 |-> ##3 flags == ($past(flags, 3) & 16'hfffe);
    endproperty
    a_clr_c: assert property (p_clr_c) else $error("clear carry result");
    property p_clr_d;
        go && op_code == 3'h1 |-> ##3 flags == ($past(flags, 3) & 16'hfbff);
    endproperty
    a_clr_d: assert property (p_clr_d) else $error("clear direction result");
    property p_clr_i;
        go && op_code == 3'h2 |-> ##3 flags == ($past(flags, 3) & 16'hfdff);
    endproperty
    a_clr_i: assert property (p_clr_i) else $error("clear interrupt result");
    property p_cmc;
        go && op_code == 3'h3 |-> ##3 flags == ($past(flags, 3) ^ 16'h0001);
    endproperty
    a_cmc: assert property (p_cmc) else $error("complement carry result");
    property p_cmp_rr;
        go && op_code == 3'h4 && cmp_form == 3'h0 |=>
            busy [*3] ##1 (done && flags[10:9] == $past(flags[10:9], 4));
    endproperty
    a_cmp_rr: assert property (p_cmp_rr) else $error("reg compare timing");
    property p_cmp_imm;
        go && op_code == 3'h4 && (cmp_form == 3'h3 || cmp_form == 3'h5) |=> busy [*4] ##1 done;
    endproperty
    a_cmp_imm: assert property (p_cmp_imm) else $error("immediate compare timing");
    property p_len_one;
        go && op_code != 3'h4 |=> enc_len == 3'h1;
    endproperty
    a_len_one: assert property (p_len_one) else $error("one byte length");
    property p_str_one;
        go && op_code == 3'h5 && !rep && !op_word |-> ##22 !done ##1 (done && xfer_cnt == 16'h0002);
    endproperty
    a_str_one: assert property (p_str_one) else $error("single string timing");
    property p_rep_zero;
        go && op_code == 3'h5 && rep && rep_count == 16'h0000 |-> ##10 (done && xfer_cnt == 16'h0000);
    endproperty
    a_rep_zero: assert property (p_rep_zero) else $error("empty repeat timing");
    c_rep: cover property (go && op_code == 3'h5 && rep);
    c_mem_imm: cover property (go && op_code == 3'h4 && cmp_form == 3'h4);
    c_flag: cover property (go && op_code == 3'h3);
endmodule // fcx_exec_unit_sva
`default_nettype wire

/* File: sim/tb_top.sv */
// Self-checking bench for the flag-control and compare unit
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import fcx_pkg::*;
;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic op_valid = 1'b0;
    logic [2:0] op_code = 3'h0;
    logic [2:0] cmp_form = 3'h0;
    logic op_word = 1'b0;
    logic [15:0] dst_val = 16'h0000;
    logic [15:0] src_val = 16'h0000;
    logic mem_odd = 1'b0;
    logic [7:0] addr_clk = 8'h00;
    logic [1:0] disp_len = 2'h0;
    logic rep_eq = 1'b0;
    logic [15:0] src_addr = 16'h0000;
    logic [15:0] dst_addr = 16'h0000;
    logic [15:0] rep_count = 16'h0000;
    logic [15:0] mem_rd_data = 16'h0000;
    logic mem_rd_valid = 1'b0;
    logic [15:0] bad_addr = 16'hffff;
    logic busy, done, mem_rd_req;
    logic use_bus8 = 1'b0;
    logic done8;
    logic [15:0] flags, xfer_cnt, mem_rd_addr, src_ptr, dst_ptr, count;
    logic [2:0] enc_len;
    int error_cnt = 0;
    int compares = 0;

    fcx_exec_unit #(.BUS8(1'b0)) dut (
        .core_clk(core_clk), .sys_rst(sys_rst), .op_valid(op_valid), .op_code(op_code),
        .cmp_form(cmp_form), .op_word(op_word), .dst_val(dst_val), .src_val(src_val),
        .mem_odd(mem_odd), .effective_address_time(addr_clk), .disp_len(disp_len),
        .repeat_while_equal_prefix(rep_eq), .src_addr(src_addr), .dst_addr(dst_addr),
        .rep_count(rep_count), .mem_rd_data(mem_rd_data), .mem_rd_valid(mem_rd_valid),
        .busy(busy), .done(done), .flags(flags), .enc_len(enc_len), .xfer_cnt(xfer_cnt),
        .mem_rd_req(mem_rd_req), .mem_rd_addr(mem_rd_addr), .src_ptr(src_ptr),
        .dst_ptr(dst_ptr), .count(count)
    );

    // Narrow-bus copy; only compares reach it, so no memory replies needed
    fcx_exec_unit #(.BUS8(1'b1)) dut_bus8 (
        .core_clk(core_clk), .sys_rst(sys_rst), .op_valid(op_valid && use_bus8), .op_code(op_code),
        .cmp_form(cmp_form), .op_word(op_word), .dst_val(dst_val), .src_val(src_val),
        .mem_odd(mem_odd), .effective_address_time(addr_clk), .disp_len(disp_len),
        .repeat_while_equal_prefix(rep_eq), .src_addr(src_addr), .dst_addr(dst_addr),
        .rep_count(rep_count), .mem_rd_data(mem_rd_data), .mem_rd_valid(mem_rd_valid),
        .busy(), .done(done8), .flags(), .enc_len(), .xfer_cnt(), .mem_rd_req(), .mem_rd_addr(),
        .src_ptr(), .dst_ptr(), .count()
    );

    always #5 core_clk = ~core_clk;

    // Low address byte as data; one poisoned address forces a mismatch
    function automatic logic [15:0] memv(input logic [15:0] a);
        return (a & 16'h00ff) ^ {15'h0000, a == bad_addr};
    endfunction

    // Answers each read one cycle later; idle data toggles so stale values never match
    always @(posedge core_clk) begin : mem_resp
        logic req;
        logic [15:0] a;
        req = mem_rd_req;
        a = mem_rd_addr;
        #1;
        mem_rd_valid = req;
        mem_rd_data = req ? memv(a) : ~mem_rd_data;
    end

    function automatic logic [15:0] sub_flags(input logic [15:0] d, input logic [15:0] s, input logic w);
        logic [16:0] r;
        logic [15:0] f;
        int m;
        r = w ? ({1'b0, d} - {1'b0, s}) : ({9'h000, d[7:0]} - {9'h000, s[7:0]});
        m = w ? 15 : 7;
        f = 16'h0000;
        f[FCX_FLAG_C] = w ? r[16] : r[8];
        f[FCX_FLAG_P] = ~^r[7:0];
        f[FCX_FLAG_A] = d[3:0] < s[3:0];
        f[FCX_FLAG_Z] = w ? (r[15:0] == 16'h0000) : (r[7:0] == 8'h00);
        f[FCX_FLAG_S] = r[m];
        f[FCX_FLAG_O] = (d[m] != s[m]) && (r[m] != d[m]);
        return f;
    endfunction

    task automatic tally_and_finish();
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Returns clocks from take to completion; bounded wait
    task automatic issue(input logic [2:0] code, output int cyc);
        op_code = code;
        op_valid = 1'b1;
        @(posedge core_clk);
        #1 op_valid = 1'b0;
        cyc = 0;
        while (done !== 1'b1 && cyc < 400) begin
            @(posedge core_clk);
            #1 cyc++;
        end
        if (cyc >= 400) begin
            error_cnt++;
            $display("MISMATCH %0t no completion", $time);
            tally_and_finish();
        end
    endtask

    task automatic t_flags();
        int c;
        logic [2:0] code;
        logic [15:0] f0;
        logic [15:0] exp;
        op_word = 1'b1;
        dst_val = 16'h0001;
        src_val = 16'h0002;
        issue(3'h4, c);
        for (int i = 0; i < 5; i++) begin
            f0 = flags;
            code = (i < 2) ? 3'h3 : 3'(i - 2);
            issue(code, c);
            case (code)
                3'h0: exp = f0 & 16'hfffe;
                3'h1: exp = f0 & 16'hfbff;
                3'h2: exp = f0 & 16'hfdff;
                default: exp = f0 ^ 16'h0001;
            endcase
            check(flags, exp, "flag op result");
            check(16'(c), FCX_CLK_FLAG, "flag op clocks");
            check({13'h0000, enc_len}, 16'h0001, "flag op length");
            check(xfer_cnt, 16'h0000, "flag op transfers");
        end
    endtask

    task automatic t_compare();
        int c;
        int n;
        int e;
        logic [15:0] f0;
        mem_odd = 1'b1;
        addr_clk = 8'h07;
        disp_len = 2'h2;
        for (int f = 0; f < 6; f++) begin
            for (int w = 0; w < 2; w++) begin
                cmp_form = 3'(f);
                op_word = w[0];
                dst_val = 16'(f * 16'h2345);
                src_val = (f == 5) ? dst_val : 16'(16'h4321 + f * 16'h1f0f);
                case (f)
                    0: n = 3;
                    3, 5: n = 4;
                    4: n = 17 + w * 4;
                    default: n = 16 + w * 4;
                endcase
                e = (f == 0) ? 2 : (f < 3) ? 4 : (f == 3) ? 3 + w : (f == 4) ? 5 + w : 2 + w;
                f0 = flags;
                issue(3'h4, c);
                check(16'(c), 16'(n), "compare clocks");
                check({13'h0000, enc_len}, 16'(e), "compare length");
                check(flags & FCX_ARITH_MASK, sub_flags(dst_val, src_val, w[0]), "compare flags");
                check(flags & ~FCX_ARITH_MASK, f0 & ~FCX_ARITH_MASK, "other flags");
            end
        end
    endtask

    // Shared string run: k passes expected, n clocks in all
    task automatic run_str(input logic r, input logic w, input logic [15:0] sa, input logic [15:0] da,
                           input logic [15:0] rc, input int n, input int k);
        int c;
        int st;
        logic [15:0] f0;
        st = w ? 2 : 1;
        f0 = flags;
        rep_eq = r;
        op_word = w;
        src_addr = sa;
        dst_addr = da;
        rep_count = rc;
        issue(3'h5, c);
        check(16'(c), 16'(n), "string clocks");
        check(xfer_cnt, 16'(2 * k), "string transfers");
        check({13'h0000, enc_len}, 16'h0001, "string length");
        check(src_ptr, 16'(sa + k * st), "source pointer");
        check(dst_ptr, 16'(da + k * st), "dest pointer");
        if (r)
            check(count, 16'(rc - k), "count left");
        if (k == 0)
            check(flags, f0, "flags kept");
        else
            check(flags & FCX_ARITH_MASK, sub_flags(memv(16'(da + (k - 1) * st)),
                  memv(16'(sa + (k - 1) * st)), w), "string flags");
    endtask

    task automatic t_str_single();
        run_str(1'b0, 1'b0, 16'h1003, 16'h2003, 16'h0000, 22, 1);
        run_str(1'b0, 1'b1, 16'h1005, 16'h2004, 16'h0000, 26, 1);
    endtask

    task automatic t_str_repeat();
        run_str(1'b1, 1'b1, 16'h1000, 16'h2000, 16'h0005, 9 + 5 * 22, 5);
        bad_addr = 16'h2004;
        run_str(1'b1, 1'b1, 16'h1000, 16'h2000, 16'h0005, 9 + 3 * 22, 3);
        run_str(1'b1, 1'b0, 16'h1000, 16'h2000, 16'h0000, 9, 0);
    endtask

    // Even word address: only the narrow bus pays the word penalty
    task automatic t_bus8();
        int c;
        int c8;
        use_bus8 = 1'b1;
        cmp_form = 3'h1;
        mem_odd = 1'b0;
        addr_clk = 8'h07;
        for (int w = 0; w < 2; w++) begin
            op_word = w[0];
            issue(3'h4, c);
            c8 = c;
            while (done8 !== 1'b1 && c8 < 400) begin
                @(posedge core_clk);
                #1 c8++;
            end
            check(16'(c), 16'(16), "wide bus even clocks");
            check(16'(c8), 16'(16 + w * 4), "narrow bus clocks");
        end
        use_bus8 = 1'b0;
    endtask

    initial begin
        repeat (8) @(posedge core_clk);
        #1 sys_rst = 1'b0;
        check(flags, FCX_FLAGS_RST, "reset flags");
        t_flags();
        t_compare();
        t_str_single();
        t_str_repeat();
        t_bus8();
        tally_and_finish();
    end
endmodule // tb_top

bind fcx_exec_unit fcx_exec_unit_sva u_sva (
    .core_clk(core_clk), .sys_rst(sys_rst), .op_valid(op_valid), .op_code(op_code),
    .cmp_form(cmp_form), .op_word(op_word), .repeat_while_equal_prefix(repeat_while_equal_prefix),
    .rep_count(rep_count), .busy(busy), .done(done), .flags(flags), .enc_len(enc_len),
    .xfer_cnt(xfer_cnt)
);
`default_nettype wire
